// *** design/diag_pkg.sv ***
// Functional notes
// - Byte 0 bit 0: module failure from lost interrupt, supply loss or overload.
// - Byte 0 bit 1: internal error from supply loss or output overload.
// - Byte 0 bit 2: set while an external error is present.
// - Byte 0 bit 3: set while a channel error is present.
// - Byte 0 bit 4: external supply missing; bits 7 to 5 read zero.
// - Byte 1 bits 3 to 0: class 1111b digital or 1000b function; 7 to 5 zero.
// - Byte 1 bit 4: channel information present for lost interrupt, supply or overload.
// - Byte 2 bit 4: internal input or output supply missing; other bits zero.
// - Incoming byte 3 bit 6: process interrupt lost; other bits zero.
// - After errors clear, outgoing record only while release enabled; byte 3 zero.
// - Record set 0 layout is identical in every operating mode.
// - Record set 1 is record set 0 plus twelve module-specific bytes.
// - Alarm mode byte 4: type 70h in bits 6 to 0, bit 7 more types.
// - Byte 5 holds diagnostic bits per channel, 08h in alarm mode.
// - Byte 6 holds channel count, 08h in alarm mode.
// - Byte 7 bits 0 and 1 flag errors in four-input groups; 7 to 2 zero.
// - Bytes 8 and 9: lost flag per input at even bits; odd bits and bytes 10 to 11 zero.
`default_nettype none
package diag_pkg;
  localparam int AW = 5;
  localparam int DW = 8;
  typedef logic [15:0][7:0] record_type;
  typedef enum logic [1:0] {
    MODE_ALARM   = 2'b00,
    MODE_COUNTER = 2'b01,
    MODE_FREQ    = 2'b10,
    MODE_PWM     = 2'b11
  } mode_type;
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_HELD_IN  = 2'b01,
    ST_ACTIVE   = 2'b10,
    ST_HELD_OUT = 2'b11
  } fsm_type;
  // Register offsets
  localparam logic [AW-1:0] OFS_RECORD   = 5'h00;
  localparam logic [AW-1:0] OFS_CTRL     = 5'h10;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 5'h11;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 5'h12;
  localparam logic [AW-1:0] OFS_LIVE     = 5'h13;
  localparam logic [AW-1:0] OFS_ACK      = 5'h14;
  // Record field positions
  localparam int B0_FAIL    = 0;
  localparam int B0_INT     = 1;
  localparam int B0_EXT     = 2;
  localparam int B0_CHAN    = 3;
  localparam int B0_EXT_SUP = 4;
  localparam int B1_INFO    = 4;
  localparam int B2_INT_SUP = 4;
  localparam int B3_LOST    = 6;
  localparam int B4_MORE    = 7;
  // Record constants
  localparam logic [3:0] CLASS_DIGITAL   = 4'hf;
  localparam logic [3:0] CLASS_FUNCTION  = 4'h8;
  localparam logic [6:0] CHAN_TYPE_INPUT = 7'h70;
  localparam logic [7:0] DIAG_BITS       = 8'h08;
  localparam logic [7:0] CHAN_COUNT      = 8'h08;
  // Control register fields and reset
  localparam int CTRL_RELEASE = 0;
  localparam int CTRL_FUNC    = 1;
  localparam int CTRL_MORE    = 2;
  localparam int CTRL_MODE    = 4;
  localparam logic [DW-1:0] CTRL_RESET = 8'h01;
  // Interrupt status bits and reset
  localparam int IRQ_IN  = 0;
  localparam int IRQ_OUT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage
`default_nettype wire

// *** design/diag_if.sv ***
`default_nettype none
interface diag_if;
  import diag_pkg::*;
  logic              alarm_mode;
  logic              outgoing;
  logic              func_class;
  logic              more_types;
  logic              ext_fault;
  logic              ext_supply;
  logic              in_supply;
  logic              out_supply;
  logic              overload;
  logic [7:0]        lost;
  record_type        rec;
  modport owner    (output alarm_mode, outgoing, func_class, more_types, ext_fault,
                    ext_supply, in_supply, out_supply, overload, lost, input rec);
  modport composer (input alarm_mode, outgoing, func_class, more_types, ext_fault,
                    ext_supply, in_supply, out_supply, overload, lost, output rec);
endinterface
`default_nettype wire

// *** design/diag_record_compose.sv ***
`default_nettype none
module diag_record_compose
  import diag_pkg::*;
#(
  parameter int INPUTS = 8
) (
  diag_if.composer dif
);
  logic supply_loss;
  logic chan_info;
  logic lost_any;

  assign supply_loss = dif.in_supply | dif.out_supply;
  assign lost_any    = |dif.lost;
  assign chan_info   = lost_any | supply_loss | dif.overload;

  always_comb begin
    dif.rec = '0;
    // Record set 0, same in every mode
    dif.rec[0][B0_FAIL]    = chan_info;
    dif.rec[0][B0_INT]     = supply_loss | dif.overload;
    dif.rec[0][B0_EXT]     = dif.ext_fault | dif.ext_supply;
    dif.rec[0][B0_CHAN]    = chan_info;
    dif.rec[0][B0_EXT_SUP] = dif.ext_supply;
    dif.rec[1][3:0]        = dif.func_class ? CLASS_FUNCTION : CLASS_DIGITAL;
    dif.rec[1][B1_INFO]    = chan_info;
    dif.rec[2][B2_INT_SUP] = supply_loss;
    dif.rec[3][B3_LOST]    = lost_any & ~dif.outgoing;
    // Module-specific part after the four common bytes
    if (dif.alarm_mode) begin
      dif.rec[4][6:0]     = CHAN_TYPE_INPUT;
      dif.rec[4][B4_MORE] = dif.more_types;
      dif.rec[5]          = DIAG_BITS;
      dif.rec[6]          = CHAN_COUNT;
      for (int g = 0; g < INPUTS / 4; g++) begin
        dif.rec[7][g] = |dif.lost[g*4 +: 4];
      end
      for (int i = 0; i < INPUTS; i++) begin
        dif.rec[8 + i / 4][2 * (i % 4)] = dif.lost[i];
      end
    end
  end
endmodule
`default_nettype wire

// *** design/diag_record_builder.sv ***
// Decided for this implementation: the register offsets and the address-and-strobe port.
`default_nettype none
module diag_record_builder
  import diag_pkg::*;
(
  input  wire logic          SYS_CLK,
  input  wire logic          RSTN,
  input  wire logic [AW-1:0] ADDR,
  input  wire logic [DW-1:0] WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  input  wire logic [7:0]    LOST_IRQ,
  input  wire logic          IN_SUPPLY_LOSS,
  input  wire logic          OUT_SUPPLY_LOSS,
  input  wire logic          OUT_OVERLOAD,
  input  wire logic          EXT_SUPPLY_LOSS,
  input  wire logic          EXT_FAULT,
  output logic [DW-1:0]      RDATA,
  output logic               IRQ,
  output logic               ERROR_LED
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    fsm_type       fsm;
    record_type    snap;
    logic [7:0]    lost;
    logic          release_en;
    logic          func_class;
    logic          more_types;
    mode_type      mode;
    logic [1:0]    irq_stat;
    logic [1:0]    irq_mask;
    logic [DW-1:0] rdata;
    logic          irq;
    logic          led;
  } state_type;

  state_type st;
  state_type next_st;

  diag_if dif ();

  logic       ack;
  logic       err_now;
  logic [1:0] irq_set;
  logic [DW-1:0] read_value;

  ////////////////////////////////////////////////////////////////////////////////
  // Live record composition

  assign dif.alarm_mode = (st.mode == MODE_ALARM);
  assign dif.outgoing   = (st.fsm == ST_ACTIVE) && (st.lost == 8'h00);
  assign dif.func_class = st.func_class;
  assign dif.more_types = st.more_types;
  assign dif.ext_fault  = EXT_FAULT;
  assign dif.ext_supply = EXT_SUPPLY_LOSS;
  assign dif.in_supply  = IN_SUPPLY_LOSS;
  assign dif.out_supply = OUT_SUPPLY_LOSS;
  assign dif.overload   = OUT_OVERLOAD;
  assign dif.lost       = st.lost;

  diag_record_compose #(
    .INPUTS (8)
  ) u_compose (
    .dif (dif.composer)
  );

  assign ack     = WR && (ADDR == OFS_ACK);
  assign err_now = (st.lost != 8'h00) | IN_SUPPLY_LOSS | OUT_SUPPLY_LOSS | OUT_OVERLOAD
                   | EXT_SUPPLY_LOSS | EXT_FAULT;

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  always_comb begin
    read_value = 8'h00;
    // Record reads come from the frozen copy, never the live one
    if (ADDR < OFS_CTRL) begin
      read_value = st.snap[ADDR[3:0]];
    end else begin
      case (ADDR)
        OFS_CTRL:     read_value = {2'h0, st.mode, 1'b0, st.more_types, st.func_class,
                                    st.release_en};
        OFS_IRQ_STAT: read_value = {6'h00, st.irq_stat};
        OFS_IRQ_MASK: read_value = {6'h00, st.irq_mask};
        OFS_LIVE:     read_value = {st.lost[5:0], st.fsm};
        default:      read_value = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    irq_set = 2'h0;
    // Lost events accumulate; a new event beats the clear on acknowledge
    if (ack && (st.fsm == ST_HELD_IN)) begin
      next_st.lost = LOST_IRQ;
    end else begin
      next_st.lost = st.lost | LOST_IRQ;
    end
    case (st.fsm)
      ST_IDLE: begin
        if (err_now) begin
          next_st.snap = dif.rec;
          next_st.fsm  = ST_HELD_IN;
          irq_set[IRQ_IN] = 1'b1;
        end
      end
      ST_HELD_IN: begin
        if (ack) begin
          next_st.fsm = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        // Interrupts lost since the acknowledge restart the incoming report
        if (st.lost != 8'h00) begin
          next_st.snap = dif.rec;
          next_st.fsm  = ST_HELD_IN;
          irq_set[IRQ_IN] = 1'b1;
        end else if (!err_now) begin
          // All causes gone: outgoing report only with release on
          if (st.release_en) begin
            next_st.snap = dif.rec;
            next_st.fsm  = ST_HELD_OUT;
            irq_set[IRQ_OUT] = 1'b1;
          end else begin
            next_st.fsm = ST_IDLE;
          end
        end
      end
      ST_HELD_OUT: begin
        if (ack) begin
          next_st.fsm = ST_IDLE;
        end
      end
      default: begin
        next_st.fsm = ST_IDLE;
      end
    endcase
    // Register writes
    if (WR) begin
      case (ADDR)
        OFS_CTRL: begin
          next_st.release_en = WDATA[CTRL_RELEASE];
          next_st.func_class = WDATA[CTRL_FUNC];
          next_st.more_types = WDATA[CTRL_MORE];
          next_st.mode       = mode_type'(WDATA[CTRL_MODE +: 2]);
        end
        OFS_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~WDATA[1:0];
        OFS_IRQ_MASK: next_st.irq_mask = WDATA[1:0];
        default: ;
      endcase
    end
    // Hardware set wins over a clearing write
    next_st.irq_stat = next_st.irq_stat | irq_set;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
    next_st.led      = (next_st.fsm != ST_IDLE);
    next_st.rdata    = RD ? read_value : 8'h00;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      // Release on, digital class, alarm mode
      st            <= '0;
      st.fsm        <= ST_IDLE;
      st.release_en <= CTRL_RESET[CTRL_RELEASE];
      st.func_class <= CTRL_RESET[CTRL_FUNC];
      st.more_types <= CTRL_RESET[CTRL_MORE];
      st.mode       <= MODE_ALARM;
      st.irq_stat   <= IRQ_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA     = st.rdata;
  assign IRQ       = st.irq;
  assign ERROR_LED = st.led;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  chk_fail_bit: assert property (
    dif.rec[0][B0_FAIL] == ((st.lost != 8'h00) | IN_SUPPLY_LOSS | OUT_SUPPLY_LOSS
                            | OUT_OVERLOAD))
    else $error("module failure bit wrong");

  chk_internal_err: assert property (
    dif.rec[0][B0_INT] == (IN_SUPPLY_LOSS | OUT_SUPPLY_LOSS | OUT_OVERLOAD))
    else $error("internal error bit wrong");

  chk_external_err: assert property (
    (EXT_FAULT || EXT_SUPPLY_LOSS) |-> dif.rec[0][B0_EXT])
    else $error("external error bit missing");

  chk_channel_err: assert property (
    dif.rec[0][B0_CHAN] == dif.rec[1][B1_INFO])
    else $error("channel error bit disagrees with channel info");

  chk_byte0_top: assert property (
    dif.rec[0][7:5] == 3'h0 && dif.rec[0][B0_EXT_SUP] == EXT_SUPPLY_LOSS)
    else $error("byte 0 upper bits wrong");

  chk_module_class: assert property (
    dif.rec[1][3:0] == (st.func_class ? 4'h8 : 4'hf) && dif.rec[1][7:5] == 3'h0)
    else $error("module class wrong");

  chk_chan_info: assert property (
    (st.lost != 8'h00 || IN_SUPPLY_LOSS || OUT_SUPPLY_LOSS || OUT_OVERLOAD)
    |-> dif.rec[1][B1_INFO])
    else $error("channel info bit missing");

  chk_int_supply: assert property (
    dif.rec[2] == {3'h0, IN_SUPPLY_LOSS | OUT_SUPPLY_LOSS, 4'h0})
    else $error("byte 2 wrong");

  chk_lost_incoming: assert property (
    (st.fsm == ST_IDLE && LOST_IRQ != 8'h00) ##1 (st.fsm == ST_IDLE && err_now)
    |=> st.snap[3] == 8'h40)
    else $error("incoming byte 3 does not flag lost interrupt");

  chk_outgoing_sent: assert property (
    (st.fsm == ST_ACTIVE && st.lost == 8'h00 && !err_now && st.release_en
     && !WR)
    |=> st.fsm == ST_HELD_OUT && st.snap[3] == 8'h00 && st.irq_stat[IRQ_OUT])
    else $error("outgoing record not issued");

  chk_outgoing_quiet: assert property (
    (st.fsm == ST_ACTIVE && st.lost == 8'h00 && !err_now && !st.release_en)
    |=> st.fsm == ST_IDLE && !$rose(st.irq_stat[IRQ_OUT]))
    else $error("outgoing record issued without release");

  chk_alarm_header: assert property (
    st.mode == MODE_ALARM |-> dif.rec[4][6:0] == 7'h70
      && dif.rec[5] == 8'h08 && dif.rec[6] == 8'h08)
    else $error("alarm mode header bytes wrong");

  chk_group_err: assert property (
    st.mode == MODE_ALARM |-> dif.rec[7] == {6'h00, |st.lost[7:4], |st.lost[3:0]})
    else $error("group error bits wrong");

  chk_lost_spread: assert property (
    st.mode == MODE_ALARM |-> dif.rec[8] == {1'b0, st.lost[3], 1'b0, st.lost[2],
                                             1'b0, st.lost[1], 1'b0, st.lost[0]}
      && dif.rec[9] == {1'b0, st.lost[7], 1'b0, st.lost[6],
                        1'b0, st.lost[5], 1'b0, st.lost[4]})
    else $error("lost flags misplaced");

  chk_reserved_zero: assert property (
    dif.rec[12] == 8'h00 && dif.rec[13] == 8'h00 && dif.rec[14] == 8'h00
      && dif.rec[15] == 8'h00 && dif.rec[10] == 8'h00 && dif.rec[11] == 8'h00)
    else $error("reserved bytes not zero");

  chk_held_stable: assert property (
    (st.fsm == ST_HELD_IN || st.fsm == ST_HELD_OUT) && !ack |=> $stable(st.snap))
    else $error("held record changed");

  chk_read_data: assert property (
    RD && ADDR < OFS_CTRL |=> RDATA == $past(st.snap[ADDR[3:0]]) ##1 RDATA == 8'h00 || $past(RD))
    else $error("record read returned wrong byte");

  chk_irq_level: assert property (
    (st.irq_stat & st.irq_mask) != 2'h0 |-> IRQ)
    else $error("interrupt output low while unmasked status set");

  chk_irq_quiet: assert property (
    (st.irq_stat & st.irq_mask) == 2'h0 |-> !IRQ)
    else $error("interrupt output high with nothing unmasked");

  chk_led_level: assert property (
    ERROR_LED == (st.fsm != ST_IDLE))
    else $error("error lamp disagrees with record state");

  chk_rdata_idle: assert property (
    !RD |=> RDATA == 8'h00)
    else $error("read data not zero outside read answer");

  chk_status_clear: assert property (
    WR && ADDR == OFS_IRQ_STAT && irq_set == 2'h0
    |=> st.irq_stat == ($past(st.irq_stat) & ~$past(WDATA[1:0])))
    else $error("status bits not cleared by writing ones");

  chk_ctrl_write: assert property (
    WR && ADDR == OFS_CTRL
    |=> st.release_en == $past(WDATA[CTRL_RELEASE])
        && st.mode == $past(WDATA[CTRL_MODE +: 2]))
    else $error("control write not taken");

  ////////////////////////////////////////////////////////////////////////////////
  // Record content checks

  chk_byte3_fixed: assert property (
    dif.rec[3][5:0] == 6'h00 && !dif.rec[3][7])
    else $error("byte 3 fixed bits not zero");

  chk_ext_clear: assert property (
    !(EXT_FAULT || EXT_SUPPLY_LOSS) |-> !dif.rec[0][B0_EXT])
    else $error("external error bit without cause");

  chk_outgoing_byte3: assert property (
    dif.outgoing |-> dif.rec[3] == 8'h00)
    else $error("outgoing record flags lost interrupt");

  chk_mode_zero: assert property (
    st.mode != MODE_ALARM |-> dif.rec[15:4] == 96'h0)
    else $error("module-specific bytes not zero outside alarm mode");

  chk_odd_bits: assert property (
    (dif.rec[8] & 8'haa) == 8'h00 && (dif.rec[9] & 8'haa) == 8'h00
      && (dif.rec[10] & 8'haa) == 8'h00 && (dif.rec[11] & 8'haa) == 8'h00
      && dif.rec[7][7:4] == 4'h0)
    else $error("odd or reserved record bits set");

  ////////////////////////////////////////////////////////////////////////////////
  // Record flow checks

  chk_capture_in: assert property (
    st.fsm == ST_IDLE && err_now
    |=> st.fsm == ST_HELD_IN && st.irq_stat[IRQ_IN] && st.snap == $past(dif.rec))
    else $error("incoming record not captured");

  chk_idle_quiet: assert property (
    st.fsm == ST_IDLE && !err_now |=> st.fsm == ST_IDLE && $stable(st.snap))
    else $error("record changed without an error");

  chk_recapture: assert property (
    st.fsm == ST_ACTIVE && st.lost != 8'h00
    |=> st.fsm == ST_HELD_IN && st.snap[3] == 8'h40 && st.irq_stat[IRQ_IN])
    else $error("lost interrupt while active not reported");

  chk_ack_in: assert property (
    st.fsm == ST_HELD_IN && ack |=> st.fsm == ST_ACTIVE && st.lost == $past(LOST_IRQ))
    else $error("incoming acknowledge not taken");

  chk_ack_out: assert property (
    st.fsm == ST_HELD_OUT && ack |=> st.fsm == ST_IDLE)
    else $error("outgoing acknowledge not taken");

  chk_lost_sticky: assert property (
    !(ack && st.fsm == ST_HELD_IN) |=> st.lost == $past(st.lost | LOST_IRQ))
    else $error("lost flag dropped");

endmodule
`default_nettype wire

// *** verification/diag_record_builder_tb.sv ***
`default_nettype none
module diag_record_builder_tb
  import diag_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic          sys_clk;
  logic          rstn;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          wr;
  logic          rd;
  logic [7:0]    lost_irq;
  logic          in_sup;
  logic          out_sup;
  logic          overload;
  logic          ext_sup;
  logic          ext_fault;
  logic [DW-1:0] rdata;
  logic          irq;
  logic          error_led;
  int            fails;
  int            checks_done;
  int            cycles;
  logic [7:0]    exp_rec [16];

  diag_record_builder dut (
    .SYS_CLK         (sys_clk),
    .RSTN            (rstn),
    .ADDR            (addr),
    .WDATA           (wdata),
    .WR              (wr),
    .RD              (rd),
    .LOST_IRQ        (lost_irq),
    .IN_SUPPLY_LOSS  (in_sup),
    .OUT_SUPPLY_LOSS (out_sup),
    .OUT_OVERLOAD    (overload),
    .EXT_SUPPLY_LOSS (ext_sup),
    .EXT_FAULT       (ext_fault),
    .RDATA           (rdata),
    .IRQ             (irq),
    .ERROR_LED       (error_led)
  );

  always #10 sys_clk = ~sys_clk;

  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      final_report();
    end
  end

////////////////////////////////////////////////////////////////////////////////

  task automatic final_report;
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic bus_rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input string name, input logic [AW-1:0] a, input logic [7:0] e);
    logic [7:0] d;
    bus_rd(a, d);
    chk(name, e, d);
  endtask

  task automatic rec_chk(input int n);
    for (int i = 0; i < n; i++) begin
      rd_chk($sformatf("record byte %0d", i), OFS_RECORD + AW'(i), exp_rec[i]);
    end
  endtask

  // Poll the live register until the state shows up
  task automatic wait_fsm(input logic [1:0] s);
    logic [7:0] d;
    int         n;
    n = 0;
    bus_rd(OFS_LIVE, d);
    while (d[1:0] !== s && n < 20) begin
      bus_rd(OFS_LIVE, d);
      n++;
    end
    chk("record state", {6'h00, s}, {6'h00, d[1:0]});
  endtask

  task automatic pins(input logic exp_irq, input logic exp_led);
    #1;
    chk("irq", {7'h00, exp_irq}, {7'h00, irq});
    chk("error led", {7'h00, exp_led}, {7'h00, error_led});
    chk("idle read data", 8'h00, rdata);
    @(posedge sys_clk);
  endtask

////////////////////////////////////////////////////////////////////////////////

  task automatic reset_values;
    rd_chk("control", OFS_CTRL, CTRL_RESET);
    rd_chk("irq status", OFS_IRQ_STAT, 8'h00);
    rd_chk("irq mask", OFS_IRQ_MASK, 8'h00);
    rd_chk("live", OFS_LIVE, 8'h00);
    rd_chk("unmapped", 5'h1f, 8'h00);
    rd_chk("record byte 12", OFS_RECORD + 5'h0c, 8'h00);
    pins(1'b0, 1'b0);
  endtask

  task automatic lost_inputs;
    bus_wr(OFS_IRQ_MASK, 8'h03);
    lost_irq <= 8'h41;
    @(posedge sys_clk);
    lost_irq <= 8'h00;
    wait_fsm(2'd1);
    exp_rec = '{8'h09, 8'h1f, 8'h00, 8'h40, 8'h70, 8'h08, 8'h08, 8'h03,
                8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rec_chk(16);
    pins(1'b1, 1'b1);
    rd_chk("irq status", OFS_IRQ_STAT, 8'h01);
    // New loss while held, plus a refused write into the record
    lost_irq <= 8'h08;
    @(posedge sys_clk);
    lost_irq <= 8'h00;
    bus_wr(OFS_RECORD, 8'hff);
    rd_chk("live", OFS_LIVE, 8'h25);
    rec_chk(16);
    bus_wr(OFS_ACK, 8'h00);
    wait_fsm(2'd3);
    rd_chk("irq status", OFS_IRQ_STAT, 8'h03);
    exp_rec = '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h70, 8'h08, 8'h08, 8'h00,
                8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rec_chk(16);
    bus_wr(OFS_IRQ_STAT, 8'h03);
    rd_chk("irq status", OFS_IRQ_STAT, 8'h00);
    pins(1'b0, 1'b1);
    bus_wr(OFS_ACK, 8'h00);
    wait_fsm(2'd0);
    pins(1'b0, 1'b0);
  endtask

  task automatic fault_levels;
    bus_wr(OFS_CTRL, 8'h07);
    rd_chk("control", OFS_CTRL, 8'h07);
    ext_sup   <= 1'b1;
    overload  <= 1'b1;
    ext_fault <= 1'b1;
    out_sup   <= 1'b1;
    wait_fsm(2'd1);
    exp_rec = '{8'h1f, 8'h18, 8'h10, 8'h00, 8'hf0, 8'h08, 8'h08, 8'h00,
                8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rec_chk(16);
    bus_wr(OFS_ACK, 8'h00);
    repeat (5) @(posedge sys_clk);
    rd_chk("live", OFS_LIVE, 8'h02);
    ext_sup   <= 1'b0;
    overload  <= 1'b0;
    ext_fault <= 1'b0;
    out_sup   <= 1'b0;
    wait_fsm(2'd3);
    exp_rec = '{8'h00, 8'h08, 8'h00, 8'h00, 8'hf0, 8'h08, 8'h08, 8'h00,
                8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rec_chk(16);
    bus_wr(OFS_ACK, 8'h00);
    wait_fsm(2'd0);
    bus_wr(OFS_IRQ_STAT, 8'h03);
  endtask

  task automatic other_mode;
    bus_wr(OFS_IRQ_MASK, 8'h00);
    bus_wr(OFS_CTRL, 8'h10);
    rd_chk("control", OFS_CTRL, 8'h10);
    bus_wr(OFS_CTRL, 8'h20);
    rd_chk("control", OFS_CTRL, 8'h20);
    bus_wr(OFS_CTRL, 8'h30);
    rd_chk("control", OFS_CTRL, 8'h30);
    in_sup <= 1'b1;
    wait_fsm(2'd1);
    pins(1'b0, 1'b1);
    rd_chk("irq status", OFS_IRQ_STAT, 8'h01);
    exp_rec = '{8'h0b, 8'h1f, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rec_chk(16);
    in_sup <= 1'b0;
    bus_wr(OFS_ACK, 8'h00);
    wait_fsm(2'd0);
    rd_chk("irq status", OFS_IRQ_STAT, 8'h01);
    pins(1'b0, 1'b0);
  endtask

////////////////////////////////////////////////////////////////////////////////

  initial begin
    sys_clk     = 1'b0;
    rstn        = 1'b0;
    addr        = '0;
    wdata       = '0;
    wr          = 1'b0;
    rd          = 1'b0;
    lost_irq    = '0;
    in_sup      = 1'b0;
    out_sup     = 1'b0;
    overload    = 1'b0;
    ext_sup     = 1'b0;
    ext_fault   = 1'b0;
    fails       = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    reset_values();
    lost_inputs();
    fault_levels();
    other_mode();
    final_report();
  end
endmodule
`default_nettype wire
